//--- hw/pm_cap_pkg.sv
// Shared constants and carriers for the power management capability registers
package pm_cap_pkg;

  // ----------------------------------------------------------------------
  // Configuration space byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAP_HEADER_OFFSET   = 8'h44;
  localparam logic [7:0] PM_CAPS_OFFSET      = 8'h46;
  localparam logic [7:0] PM_CTRL_OFFSET      = 8'h48;
  localparam logic [7:0] PM_EXT_OFFSET       = 8'h4A;
  localparam logic [7:0] MISC_CONFIG_OFFSET  = 8'hF0;

  // ----------------------------------------------------------------------
  // Capability header and capabilities word fields
  // ----------------------------------------------------------------------
  localparam logic [7:0] CAPABILITY_IDENTIFIER = 8'h01;
  localparam logic [7:0] NEXT_ITEM_POINTER     = 8'h00;
  localparam logic [3:0] WAKE_SOURCES_ALL      = 4'hF;
  localparam logic [2:0] AUX_CURRENT_SELF      = 3'h0;
  localparam logic [2:0] AUX_CURRENT_55MA      = 3'h1;
  localparam logic [2:0] POWER_SPEC_REVISION   = 3'h2;
  localparam logic [15:0] PM_CAPS_RESET        = 16'h7E02;

  // ----------------------------------------------------------------------
  // Control and status word fields, extension word value and misc cold bit
  // ----------------------------------------------------------------------
  localparam int WAKE_STATUS_BIT   = 15;
  localparam int WAKE_ENABLE_BIT   = 8;
  localparam int COLD_CAPABLE_BIT  = 15;
  localparam logic [15:0] PM_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PM_EXT_VALUE  = 16'h0000;

  // ----------------------------------------------------------------------
  // Power levels
  // ----------------------------------------------------------------------
  localparam logic [1:0] POWER_D0 = 2'h0;
  localparam logic [1:0] POWER_D1 = 2'h1;
  localparam logic [1:0] POWER_D2 = 2'h2;
  localparam logic [1:0] POWER_D3 = 2'h3;

  // Configuration access, one dword with byte enables
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } cfg_req_s;

  // Live register state handed to the read path
  typedef struct packed {
    logic       wake_from_cold_capable;
    logic       wake_status;
    logic       wake_enable;
    logic [1:0] device_power_level;
  } pm_view_s;

endpackage

//--- hw/pm_cap_regs.sv
// Power management capability register bank in configuration space
//
// Contract
// [R1] Wake sources field reads all ones
// [R2] Capability bit 10 constant one
// [R3] Capability bit 9 constant one
// [R4] Aux current 001 when cold capable
// [R5] Capability bit 5 reads zero
// [R6] Capability bits 4 and 3 read zero
// [R7] Revision field reads 010b constantly
// [R8] Control keeps contents on D3hot exit
// [R9] Status sets on wake regardless enable
// [R10] Write one clears status and pin
// [R11] Data scale and select read zero
// [R12] Enable bit gates the wake pin
// [R13] Enable resets unless cold wake supported
// [R14] Control bits 7 to 2 zero
// [R15] Bits 1:0 hold power level
// [R16] Extension word reads all zero
// [R17] Cold bit mirrors misc bit 15
// [R18] Header id 01h, next pointer zero
// [R19] Wake pin low when status and enable
// [R20] Writes to read-only bits ignored
`timescale 1ns/10ps
`default_nettype none
module pm_cap_regs (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Configuration access
  input  wire pm_cap_pkg::cfg_req_s  i_cfg,
  output logic [31:0]                o_cfg_rdata,
  output logic                       o_cfg_ack,
  // Wake event source
  input  wire logic                  i_wake_event,
  // Power management outputs
  output logic                       o_wake_n,
  output logic [1:0]                 o_device_power_level,
  output logic                       o_d3hot_exit,
  output logic                       o_wake_from_cold_capable
);
  import pm_cap_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------

  // Dword match for a configuration byte offset
  function automatic logic dword_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
    dword_hit = (addr[7:2] == offset[7:2]);
  endfunction

  // Byte lane of a byte offset within its dword
  function automatic logic [1:0] lane_of(input logic [7:0] offset);
    lane_of = offset[1:0];
  endfunction

  // ----------------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------------

  logic        wr_ctrl_dword;
  logic        wr_misc_dword;
  logic        ctrl_lane_lo;
  logic        ctrl_lane_hi;
  logic        misc_lane_hi;
  logic [15:0] ctrl_wdata;
  logic        wake_clear;

  // Only control and misc dwords have writable bits at all
  always_comb begin
    wr_ctrl_dword = i_cfg.wr & dword_hit(i_cfg.addr, PM_CTRL_OFFSET);
    wr_misc_dword = i_cfg.wr & dword_hit(i_cfg.addr, MISC_CONFIG_OFFSET);
    // Control word sits at byte lanes 0 and 1 of its dword
    ctrl_lane_lo  = wr_ctrl_dword & i_cfg.be[lane_of(PM_CTRL_OFFSET)];
    ctrl_lane_hi  = wr_ctrl_dword & i_cfg.be[lane_of(PM_CTRL_OFFSET) + 2'h1];
    // Cold bit lives in byte lane 1 of the misc dword
    misc_lane_hi  = wr_misc_dword & i_cfg.be[1];
    ctrl_wdata    = i_cfg.wdata[15:0];
    // [R10] write one clears status
    wake_clear    = ctrl_lane_hi & ctrl_wdata[WAKE_STATUS_BIT];
  end

  // ----------------------------------------------------------------------
  // Access acknowledge
  // ----------------------------------------------------------------------

  logic cfg_ack;
  logic next_cfg_ack;

  // Every access outside reset is answered one cycle later, mapped or not
  always_comb begin
    next_cfg_ack = (i_cfg.rd | i_cfg.wr) & ~i_rst;
  end

  always_ff @(posedge i_clk) begin
    cfg_ack <= next_cfg_ack;
  end

  // ----------------------------------------------------------------------
  // Miscellaneous configuration: cold wake support
  // ----------------------------------------------------------------------

  logic wake_from_cold_capable;
  logic next_wake_from_cold_capable;

  // Software decides whether cold wake is advertised
  always_comb begin
    next_wake_from_cold_capable = wake_from_cold_capable;
    if (misc_lane_hi) begin
      // [R17] cold bit from misc register
      next_wake_from_cold_capable = i_cfg.wdata[COLD_CAPABLE_BIT];
    end
    if (i_rst) begin
      next_wake_from_cold_capable = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    wake_from_cold_capable <= next_wake_from_cold_capable;
  end

  // ----------------------------------------------------------------------
  // Wake enable
  // ----------------------------------------------------------------------

  logic wake_enable;
  logic next_wake_enable;

  // The cold bit is sampled before the reset clears it, so a device
  // that was cold capable keeps its enable through a one-cycle reset
  always_comb begin
    next_wake_enable = wake_enable;
    if (ctrl_lane_hi) begin
      // [R12] enable bit is read/write
      next_wake_enable = ctrl_wdata[WAKE_ENABLE_BIT];
    end
    if (i_rst && !wake_from_cold_capable) begin
      // [R13] cleared unless cold wake
      next_wake_enable = PM_CTRL_RESET[WAKE_ENABLE_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    wake_enable <= next_wake_enable;
  end

  // ----------------------------------------------------------------------
  // Power level
  // ----------------------------------------------------------------------

  logic [1:0] device_power_level;
  logic [1:0] next_device_power_level;
  logic       d3hot_exit;
  logic       next_d3hot_exit;

  // Any of the four codes is legal, so the value is stored as written.
  // Leaving D3hot for D0 resets the rest of the function; this bank
  // only reports that event and is itself reset solely by i_rst.
  always_comb begin
    next_device_power_level = device_power_level;
    next_d3hot_exit         = 1'b0;
    if (ctrl_lane_lo) begin
      // [R15] power level from bits 1:0
      next_device_power_level = ctrl_wdata[1:0];
      next_d3hot_exit = (device_power_level == POWER_D3) &&
                        (ctrl_wdata[1:0] == POWER_D0);
    end
    if (i_rst) begin
      next_device_power_level = PM_CTRL_RESET[1:0];
      next_d3hot_exit         = 1'b0;
    end
  end

  // [R8] no internal reset reaches these
  always_ff @(posedge i_clk) begin
    device_power_level <= next_device_power_level;
    d3hot_exit         <= next_d3hot_exit;
  end

  // ----------------------------------------------------------------------
  // Wake status and wake pin
  // ----------------------------------------------------------------------

  logic wake_status;
  logic wake_n;

  // [R9] status set ignoring enable
  pm_wake_latch u_wake (
    .i_clk         (i_clk),
    .i_rst         (i_rst),
    .i_event       (i_wake_event),
    .i_clear       (wake_clear),
    .i_enable      (next_wake_enable),
    .i_keep        (wake_from_cold_capable),
    .o_wake_status (wake_status),
    .o_wake_n      (wake_n)
  );

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------

  pm_view_s    view;
  logic [31:0] cfg_rdata;

  // Read data reflects state as it stands when the read is taken
  always_comb begin
    view.wake_from_cold_capable = wake_from_cold_capable;
    view.wake_status            = wake_status;
    view.wake_enable            = wake_enable;
    view.device_power_level     = device_power_level;
  end

  // [R20] read-only bits built, never stored
  pm_read_mux u_read (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_rd    (i_cfg.rd),
    .i_addr  (i_cfg.addr),
    .i_view  (view),
    .o_rdata (cfg_rdata)
  );

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  // All outputs come from flops above; these only rename them
  assign o_cfg_rdata              = cfg_rdata;
  assign o_cfg_ack                = cfg_ack;
  assign o_wake_n                 = wake_n;
  assign o_device_power_level     = device_power_level;
  assign o_d3hot_exit             = d3hot_exit;
  assign o_wake_from_cold_capable = wake_from_cold_capable;

endmodule
`default_nettype wire

//--- hw/pm_read_mux.sv
// Registered read data path for the capability dwords
`timescale 1ns/10ps
`default_nettype none
module pm_read_mux (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Request
  input  wire logic                  i_rd,
  input  wire logic [7:0]            i_addr,
  input  wire pm_cap_pkg::pm_view_s  i_view,
  // Answer
  output logic [31:0]                o_rdata
);
  import pm_cap_pkg::*;

  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [15:0] caps;
  logic [15:0] ctrl;

  // Capabilities and control words built from constants and live state
  always_comb begin
    // [R1] wake sources, [R2] [R3] low states
    caps = {i_view.wake_from_cold_capable, WAKE_SOURCES_ALL, 1'b1, 1'b1,
            // [R4] aux current from cold bit
            (i_view.wake_from_cold_capable ? AUX_CURRENT_55MA : AUX_CURRENT_SELF),
            // [R5] [R6] zero bits, [R7] revision
            3'h0, POWER_SPEC_REVISION};
    // [R11] [R14] zero fields of control
    ctrl = {i_view.wake_status, 6'h00, i_view.wake_enable, 6'h00,
            i_view.device_power_level};
    next_rdata = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr[7:2] == CAP_HEADER_OFFSET[7:2]) begin
        // [R18] header id and pointer
        next_rdata = {caps, NEXT_ITEM_POINTER, CAPABILITY_IDENTIFIER};
      end else if (i_addr[7:2] == PM_CTRL_OFFSET[7:2]) begin
        // [R16] extension reads zero
        next_rdata = {PM_EXT_VALUE, ctrl};
      end else if (i_addr[7:2] == MISC_CONFIG_OFFSET[7:2]) begin
        next_rdata = {16'h0000, i_view.wake_from_cold_capable, 15'h0000};
      end
    end
    if (i_rst) begin
      next_rdata = 32'h0000_0000;
    end
  end

  // Data returns to zero on every cycle without a read, so it is valid only alongside the ack
  always_ff @(posedge i_clk) begin
    rdata <= next_rdata;
  end

  assign o_rdata = rdata;
endmodule
`default_nettype wire

//--- hw/pm_wake_latch.sv
// Sticky wake status flag and the active-low wake pin it drives
`timescale 1ns/10ps
`default_nettype none
module pm_wake_latch (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // Control
  input  wire logic i_event,
  input  wire logic i_clear,
  input  wire logic i_enable,
  input  wire logic i_keep,
  // Status
  output logic      o_wake_status,
  output logic      o_wake_n
);
  logic wake_status;
  logic next_wake_status;
  logic wake_n;
  logic next_wake_n;

  // Set wins over a clear in the same cycle so no event is lost
  always_comb begin
    next_wake_status = i_event | (wake_status & ~i_clear);
    if (i_rst && !i_keep) begin
      next_wake_status = 1'b0;
    end
    // [R19] pin follows status and enable
    next_wake_n = ~(next_wake_status & i_enable);
  end

  // Status is kept through a one-cycle reset when cold wake is supported
  always_ff @(posedge i_clk) begin
    wake_status <= next_wake_status;
    wake_n      <= next_wake_n;
  end

  assign o_wake_status = wake_status;
  assign o_wake_n      = wake_n;
endmodule
`default_nettype wire

//--- sim/pm_cap_regs_monitor.sv
// Port-level assertions for the power management capability register bank
`timescale 1ns/10ps
`default_nettype none
module pm_cap_regs_monitor (
  // Clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_rst,
  // Watched ports
  input wire pm_cap_pkg::cfg_req_s i_cfg,
  input wire logic [31:0]          o_cfg_rdata,
  input wire logic                 o_cfg_ack,
  input wire logic                 i_wake_event,
  input wire logic                 o_wake_n,
  input wire logic [1:0]           o_device_power_level,
  input wire logic                 o_d3hot_exit,
  input wire logic                 o_wake_from_cold_capable
);
  import pm_cap_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Decoded accesses, address bits 1:0 do not select anything
  logic rd_caps;
  logic rd_ctrl;
  logic wr_ctrl;
  logic wr_misc;
  assign rd_caps = i_cfg.rd && (i_cfg.addr[7:2] == CAP_HEADER_OFFSET[7:2]);
  assign rd_ctrl = i_cfg.rd && (i_cfg.addr[7:2] == PM_CTRL_OFFSET[7:2]);
  assign wr_ctrl = i_cfg.wr && (i_cfg.addr[7:2] == PM_CTRL_OFFSET[7:2]);
  assign wr_misc = i_cfg.wr && (i_cfg.addr[7:2] == MISC_CONFIG_OFFSET[7:2]);

  a_ack_follows_req: assert property ((i_cfg.rd || i_cfg.wr) |=> o_cfg_ack)
    else $error("access not acknowledged next cycle");
  a_caps_word_value: assert property (rd_caps |=> o_cfg_rdata ==
    {(o_wake_from_cold_capable ? 16'hFE42 : PM_CAPS_RESET), NEXT_ITEM_POINTER, CAPABILITY_IDENTIFIER})
    else $error("capability dword wrong");
  a_ctrl_zero_fields: assert property (rd_ctrl |=> o_cfg_rdata[31:16] == 16'h0000 &&
    o_cfg_rdata[14:9] == 6'h00 && o_cfg_rdata[7:2] == 6'h00) else $error("zero fields not zero");
  a_level_read_back: assert property (rd_ctrl |=> o_cfg_rdata[1:0] == o_device_power_level)
    else $error("power level read differs from output");
  a_level_write_taken: assert property (wr_ctrl && i_cfg.be[0] |=>
    o_device_power_level == $past(i_cfg.wdata[1:0])) else $error("power level not written");
  a_pin_needs_enable: assert property (rd_ctrl |=> o_cfg_rdata[8] || o_wake_n)
    else $error("wake pin low with enable clear");
  a_pin_follows_both: assert property (rd_ctrl ##1 (o_cfg_rdata[15] && o_cfg_rdata[8]) |-> !o_wake_n)
    else $error("wake pin high with status and enable set");
  a_clear_releases: assert property (wr_ctrl && i_cfg.be[1] && i_cfg.wdata[15] && !i_wake_event
    |=> o_wake_n) else $error("clear write did not release wake pin");
  a_cold_mirror: assert property (wr_misc && i_cfg.be[1] |=>
    o_wake_from_cold_capable == $past(i_cfg.wdata[15])) else $error("cold capable bit not mirrored");
  a_exit_pulse_cause: assert property (o_d3hot_exit |->
    o_device_power_level == POWER_D0 && $past(o_device_power_level) == POWER_D3)
    else $error("exit pulse without leaving level three");

  // Main scenarios reached
  c_caps_cold: cover property (rd_caps && o_wake_from_cold_capable);
  c_exit_pulse: cover property (o_d3hot_exit);
  c_pin_low: cover property (!o_wake_n);
endmodule

bind pm_cap_regs pm_cap_regs_monitor u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack),
  .i_wake_event(i_wake_event), .o_wake_n(o_wake_n), .o_device_power_level(o_device_power_level),
  .o_d3hot_exit(o_d3hot_exit), .o_wake_from_cold_capable(o_wake_from_cold_capable)
);
`default_nettype wire

//--- sim/pm_host_model.sv
// Configuration host that issues single-dword accesses to the bank
`timescale 1ns/10ps
`default_nettype none
module pm_host_model (
  // Clock
  input  wire logic                i_clk,
  // Request to the bank
  output var pm_cap_pkg::cfg_req_s o_cfg
);
  import pm_cap_pkg::*;
  initial o_cfg = '0;

  // One access held over its taking edge; released fields are scrambled so stale data never looks valid
  task automatic access(input logic r, input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge i_clk);
    o_cfg <= '{rd: r, wr: !r, addr: a, be: b, wdata: d};
    @(posedge i_clk);
    o_cfg <= {2'b00, ~o_cfg[43:0]};
  endtask
endmodule
`default_nettype wire

//--- sim/tb_pm_cap_regs.sv
// Self-checking bench for the capability register bank
`timescale 1ns/10ps
`default_nettype none
module tb_pm_cap_regs;
  import pm_cap_pkg::*;
  logic        i_clk, i_rst, i_wake_event, o_cfg_ack, o_wake_n, o_d3hot_exit, cold;
  cfg_req_s    i_cfg;
  logic [31:0] o_cfg_rdata, d;
  logic [1:0]  level;
  logic [31:0] exp_q[$];
  int          mismatches, check_count;
  int          seed = 32'h23e7;
  localparam logic [31:0] CAPS0 = {PM_CAPS_RESET, NEXT_ITEM_POINTER, CAPABILITY_IDENTIFIER};

  always #20 i_clk = ~i_clk;
  pm_host_model u_host (.i_clk(i_clk), .o_cfg(i_cfg));
  pm_cap_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_ack(o_cfg_ack), .i_wake_event(i_wake_event), .o_wake_n(o_wake_n),
    .o_device_power_level(level), .o_d3hot_exit(o_d3hot_exit), .o_wake_from_cold_capable(cold));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Every access notes its expected read data, writes answer zero
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.access(1'b1, a, 4'h0, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    exp_q.push_back(32'h0);
    u_host.access(1'b0, a, b, v);
  endtask
  task automatic pulse(input bit r);
    @(posedge i_clk);
    if (r) i_rst <= 1'b1; else i_wake_event <= 1'b1;
    // A mid-run reset spans one edge: stickiness follows the cold bit seen at that edge
    repeat (r ? 1 : 2) @(posedge i_clk);
    i_rst <= 1'b0;
    i_wake_event <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask

  // Acknowledge watcher: each answer is matched with the oldest note
  always @(posedge i_clk) begin
    if (o_cfg_ack === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected ack", 32'h0, 32'h1);
      else chk("rdata", exp_q.pop_front(), o_cfg_rdata);
    end
  end

  // Watchdog against a hung run
  initial begin
    repeat (3000) @(posedge i_clk);
    chk("timeout", 32'h0, 32'h1);
    test_done();
  end

  initial begin
    i_clk = 1'b0;
    i_rst <= 1'b1;
    i_wake_event <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(CAP_HEADER_OFFSET, CAPS0);
    rd(PM_CTRL_OFFSET, 32'h0);
    rd(8'h4C, 32'h0);
    wr(CAP_HEADER_OFFSET, 4'hF, 32'hFFFF_FFFF);
    rd(CAP_HEADER_OFFSET, CAPS0);
    $display("test read map done");
    for (int l = 0; l < 4; l++) begin
      d = $random(seed);
      wr(PM_CTRL_OFFSET, 4'h1, {d[31:2], 2'(l)});
      rd(PM_CTRL_OFFSET, {30'h0, 2'(l)});
      #1 chk("level", {30'h0, 2'(l)}, {30'h0, level});
    end
    wr(PM_CTRL_OFFSET, 4'h3, 32'h0000_0103);
    wr(PM_CTRL_OFFSET, 4'h1, 32'h0);
    #1 chk("d3hot_exit", 32'h1, {31'h0, o_d3hot_exit});
    rd(PM_CTRL_OFFSET, 32'h0000_0100);
    $display("test power levels done");
    wr(PM_CTRL_OFFSET, 4'h2, 32'h0);
    pulse(1'b0);
    chk("wake_n", 32'h1, {31'h0, o_wake_n});
    rd(PM_CTRL_OFFSET, 32'h0000_8000);
    wr(PM_CTRL_OFFSET, 4'h2, 32'h0000_0100);
    #1 chk("wake_n", 32'h0, {31'h0, o_wake_n});
    rd(PM_CTRL_OFFSET, 32'h0000_8100);
    wr(PM_CTRL_OFFSET, 4'h2, 32'h0000_8100);
    #1 chk("wake_n", 32'h1, {31'h0, o_wake_n});
    rd(PM_CTRL_OFFSET, 32'h0000_0100);
    $display("test wake done");
    wr(MISC_CONFIG_OFFSET, 4'h2, 32'h0000_8000);
    #1 chk("cold", 32'h1, {31'h0, cold});
    rd(CAP_HEADER_OFFSET, {16'hFE42, 16'h0001});
    pulse(1'b0);
    pulse(1'b1);
    rd(PM_CTRL_OFFSET, 32'h0000_8100);
    wr(PM_CTRL_OFFSET, 4'h2, 32'h0000_8000);
    rd(PM_CTRL_OFFSET, 32'h0);
    wr(PM_CTRL_OFFSET, 4'h2, 32'h0000_0100);
    pulse(1'b1);
    rd(PM_CTRL_OFFSET, 32'h0);
    $display("test sticky enable done");
    for (int i = 0; i < 4 && exp_q.size() != 0; i++) @(posedge i_clk);
    chk("pending", 32'h0, 32'(exp_q.size()));
    test_done();
  end
endmodule
`default_nettype wire
